/* core/rcs_top.sv */
// Purpose: Reset cause status with AXI4-Lite access and event interrupt
// Assumes: Detector inputs synchronous to aclk; aresetn is power-on
// Notes:   Register 0x00 cause, 0x04 control, 0x08 events, 0x0C mask
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module rcs_top (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire rcs_pkg::rcs_det_t   det,
  input  wire rcs_pkg::rcs_instr_t instr,
  input  wire rcs_pkg::rcs_fault_t fault,
  output logic                     mcu_reset_req,
  output logic [2:0]               exception_req,
  output logic                     cpu_halt,
  output logic                     watchdog_service,
  output logic                     irq
);
  function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
    hits = (a[7:2] == off[7:2]);
  endfunction

  rcs_pkg::rcs_ctrl_t  ctrl_r;
  rcs_pkg::rcs_cause_t cause_w;
  logic [7:0]          flags_r;
  logic                fire_w;
  logic [2:0]          evt_r;
  logic [2:0]          evt_nxt;
  logic [2:0]          evt_set_w;
  logic [2:0]          evt_clr_w;
  logic [2:0]          mask_r;
  logic [7:0]          aw_addr_r;
  logic                aw_got_r;
  logic [31:0]         w_data_r;
  logic [3:0]          w_strb_r;
  logic                w_got_r;
  logic                aw_take_w;
  logic                w_take_w;
  logic                wr_do_w;
  logic                ar_take_w;
  logic                wr_map_w;
  logic                rd_map_w;
  logic [31:0]         rd_data_w;
  logic                op_bad_w;
  logic                fault_any_w;
  logic                exc_ok_w;
  logic [2:0]          exc_nxt;
  logic                halt_nxt;

  // Opcode legality
  assign op_bad_w = (instr.undefined & (instr.opcode != rcs_pkg::ILLEGAL_OPCODE))
                  | (instr.privileged & instr.user_mode)
                  | (instr.is_stop & ~ctrl_r.stop_enable & ~ctrl_r.wait_enable)
                  | (instr.is_halt & ~ctrl_r.background_debug_enable);

  assign fault_any_w = fault.illegal_addr | fault.addr_error
                     | fault.rte_format | fault.fault_on_fault;

  // Qualified reset causes
  assign cause_w.lv   = det.lv_trip & ctrl_r.low_voltage_reset_enable;
  assign cause_w.pin  = det.ext_pin_low;
  assign cause_w.wdog = det.wdog_timeout & (ctrl_r.watchdog_timeout_select != 2'h0);
  assign cause_w.illegal_opcode_flag = instr.valid & op_bad_w;
  assign cause_w.illegal_address_flag = fault_any_w & ~ctrl_r.address_reset_disable;
  assign cause_w.clock_loss_flag  = det.clk_lost & ctrl_r.clock_monitor_enable;
  assign cause_w.dbg  = det.debug_force_reset;

  rcs_cause_capture u_capture (
    .aclk    (aclk),
    .aresetn (aresetn),
    .cause   (cause_w),
    .flags_r (flags_r),
    .fire_r  (fire_w)
  );

  // Exceptions in place of resets while address reset is disabled
  assign exc_ok_w = ctrl_r.address_reset_disable & ~(|cause_w);
  assign exc_nxt  = {fault.rte_format, fault.addr_error, fault.illegal_addr}
                  & {3{exc_ok_w & ~fault.fault_on_fault}};
  assign halt_nxt = fire_w ? 1'b0
                  : (cpu_halt | (exc_ok_w & fault.fault_on_fault));

  // AXI write side
  assign aw_take_w = s_axi_awvalid & s_axi_awready;
  assign w_take_w  = s_axi_wvalid & s_axi_wready;
  assign wr_do_w   = aw_got_r & w_got_r & ~s_axi_bvalid;
  assign wr_map_w  = hits(aw_addr_r, rcs_pkg::ADDR_CAUSE) | hits(aw_addr_r, rcs_pkg::ADDR_CTRL)
                   | hits(aw_addr_r, rcs_pkg::ADDR_EVT) | hits(aw_addr_r, rcs_pkg::ADDR_MASK);

  // AXI read side
  assign ar_take_w = s_axi_arvalid & s_axi_arready;
  assign rd_map_w  = hits(s_axi_araddr, rcs_pkg::ADDR_CAUSE) | hits(s_axi_araddr, rcs_pkg::ADDR_CTRL)
                   | hits(s_axi_araddr, rcs_pkg::ADDR_EVT) | hits(s_axi_araddr, rcs_pkg::ADDR_MASK);
  assign rd_data_w = hits(s_axi_araddr, rcs_pkg::ADDR_CAUSE) ? {24'h000000, flags_r}
                   : hits(s_axi_araddr, rcs_pkg::ADDR_CTRL)  ? {24'h000000, ctrl_r}
                   : hits(s_axi_araddr, rcs_pkg::ADDR_EVT)   ? {29'h00000000, evt_r}
                   : hits(s_axi_araddr, rcs_pkg::ADDR_MASK)  ? {29'h00000000, mask_r}
                   : 32'h00000000;

  // Sticky events; a new event wins over the read clear
  assign evt_set_w[rcs_pkg::EV_RESET] = fire_w;
  assign evt_set_w[rcs_pkg::EV_EXC]   = |exc_nxt;
  assign evt_set_w[rcs_pkg::EV_HALT]  = halt_nxt & ~cpu_halt;
  assign evt_clr_w = (ar_take_w & hits(s_axi_araddr, rcs_pkg::ADDR_EVT)) ? 3'h7 : 3'h0;
  assign evt_nxt   = (evt_r & ~evt_clr_w) | evt_set_w;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      s_axi_awready <= 1'b1;
    end else if (aw_take_w) begin
      aw_got_r  <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid & s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end else if (wr_do_w) begin
      aw_got_r  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r  <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (w_take_w) begin
      w_got_r  <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid & s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end else if (wr_do_w) begin
      w_got_r  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rcs_pkg::RESP_OKAY;
    end else if (wr_do_w) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map_w ? rcs_pkg::RESP_OKAY : rcs_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Writes to the cause address only service the watchdog
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      watchdog_service <= 1'b0;
    end else begin
      watchdog_service <= wr_do_w & hits(aw_addr_r, rcs_pkg::ADDR_CAUSE);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= rcs_pkg::CTRL_RESET;
    end else if (wr_do_w & w_strb_r[0] & hits(aw_addr_r, rcs_pkg::ADDR_CTRL)) begin
      ctrl_r <= w_data_r[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= 3'h0;
    end else if (wr_do_w & w_strb_r[0] & hits(aw_addr_r, rcs_pkg::ADDR_MASK)) begin
      mask_r <= w_data_r[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= rcs_pkg::RESP_OKAY;
    end else if (ar_take_w) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data_w;
      s_axi_rresp   <= rd_map_w ? rcs_pkg::RESP_OKAY : rcs_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_r <= rcs_pkg::EVT_RESET;
      irq   <= 1'b0;
    end else begin
      evt_r <= evt_nxt;
      irq   <= |(evt_nxt & mask_r);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mcu_reset_req <= 1'b0;
      exception_req <= 3'h0;
      cpu_halt      <= 1'b0;
    end else begin
      mcu_reset_req <= fire_w;
      exception_req <= exc_nxt;
      cpu_halt      <= halt_nxt;
    end
  end
endmodule

/* include/rcs_pkg.sv */
// What this block does
// - Cause register is read only; software writes never change its flags.
// - A debug forced reset leaves every cause flag cleared.
// - Any write to the cause register address restarts the watchdog; flags unchanged.
// - Power-on reset sets bit 7 and bit 1, all others cleared.
// - Low-voltage reset keeps bit 7, sets bit 1, clears bits 6 to 2.
// - Other resets set pin, watchdog, opcode, address flags per active source.
// - Bit 6 flags a reset from a low level on the external pin.
// - Bit 5 flags a watchdog time-out; a zero time-out select blocks it.
// - Bit 4 flags illegal, unimplemented or privileged-in-user opcodes, except 0x4AFC.
// - Stop is illegal with stop and wait disabled; halt without debug enable.
// - With address reset enabled, address faults reset and set bit 3.
// - With address reset disabled, raise an exception; fault-on-fault halts instead.
// - Bit 2 flags loss of clock, only while clock monitor is enabled.
// - Supply trip with low-voltage reset enabled resets and sets bit 1.
//
// Purpose: Shared constants and carriers of the reset cause logic
// Assumes: 32-bit AXI4-Lite register window, 8-bit address
// Notes:   Constants and struct types only
package rcs_pkg;
  localparam logic [7:0]  ADDR_CAUSE     = 8'h00;
  localparam logic [7:0]  ADDR_CTRL      = 8'h04;
  localparam logic [7:0]  ADDR_EVT       = 8'h08;
  localparam logic [7:0]  ADDR_MASK      = 8'h0C;
  localparam int unsigned BIT_POR        = 7;
  localparam int unsigned BIT_PIN        = 6;
  localparam int unsigned BIT_WDOG       = 5;
  localparam int unsigned BIT_ILLEGAL_OPCODE_FLAG       = 4;
  localparam int unsigned BIT_ILLEGAL_ADDRESS_FLAG       = 3;
  localparam int unsigned BIT_LOC        = 2;
  localparam int unsigned BIT_LV         = 1;
  localparam logic [7:0]  CAUSE_POR      = 8'h82;
  localparam logic [7:0]  CTRL_RESET     = 8'hC6;
  localparam logic [2:0]  EVT_RESET      = 3'h0;
  localparam logic [2:0]  EVT_W          = 3'h3;
  localparam int unsigned EV_RESET       = 0;
  localparam int unsigned EV_EXC         = 1;
  localparam int unsigned EV_HALT        = 2;
  localparam logic [15:0] ILLEGAL_OPCODE = 16'h4AFC;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic [1:0] watchdog_timeout_select;
    logic       low_voltage_reset_enable;
    logic       clock_monitor_enable;
    logic       address_reset_disable;
    logic       background_debug_enable;
    logic       wait_enable;
    logic       stop_enable;
  } rcs_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] opcode;
    logic        undefined;
    logic        privileged;
    logic        user_mode;
    logic        is_stop;
    logic        is_halt;
  } rcs_instr_t;

  typedef struct packed {
    logic illegal_addr;
    logic addr_error;
    logic rte_format;
    logic fault_on_fault;
  } rcs_fault_t;

  typedef struct packed {
    logic ext_pin_low;
    logic wdog_timeout;
    logic clk_lost;
    logic lv_trip;
    logic debug_force_reset;
  } rcs_det_t;

  typedef struct packed {
    logic lv;
    logic pin;
    logic wdog;
    logic illegal_opcode_flag;
    logic illegal_address_flag;
    logic clock_loss_flag;
    logic dbg;
  } rcs_cause_t;
endpackage

/* core/rcs_cause_capture.sv */
// Purpose: Holds the reset cause flags and raises reset entry
// Assumes: aresetn is the power-on reset of this logic
// Notes:   Flags load once, on the first cycle any cause is active
`timescale 1ns/1ps
module rcs_cause_capture (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire rcs_pkg::rcs_cause_t cause,
  output logic [7:0]              flags_r,
  output logic                    fire_r
);
  logic       any_w;
  logic       any_d_r;
  logic       entry_w;
  logic [7:0] flags_nxt;

  assign any_w   = |cause;
  assign entry_w = any_w & ~any_d_r;

  always_comb begin
    flags_nxt = flags_r;
    if (entry_w) begin
      flags_nxt = 8'h00;
      if (cause.lv) begin
        flags_nxt[rcs_pkg::BIT_POR] = flags_r[rcs_pkg::BIT_POR];
        flags_nxt[rcs_pkg::BIT_LV]  = 1'b1;
      end else begin
        flags_nxt[rcs_pkg::BIT_PIN]  = cause.pin;
        flags_nxt[rcs_pkg::BIT_WDOG] = cause.wdog;
        flags_nxt[rcs_pkg::BIT_ILLEGAL_OPCODE_FLAG] = cause.illegal_opcode_flag;
        flags_nxt[rcs_pkg::BIT_ILLEGAL_ADDRESS_FLAG] = cause.illegal_address_flag;
        flags_nxt[rcs_pkg::BIT_LOC]  = cause.clock_loss_flag;
      end
    end
    flags_nxt[0] = 1'b0;
  end

  // Debug force alone sets no bit, so entry clears all flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r <= rcs_pkg::CAUSE_POR;
      any_d_r <= 1'b0;
      fire_r  <= 1'b0;
    end else begin
      flags_r <= flags_nxt;
      any_d_r <= any_w;
      fire_r  <= entry_w;
    end
  end
endmodule

/* tb/rcs_monitor.sv */
// Purpose: Port checker of rcs_top
// Assumes: One aclk domain, aresetn synchronous
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module rcs_monitor (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic [7:0]          s_axi_awaddr,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_bvalid,
  input wire logic [7:0]          s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire rcs_pkg::rcs_fault_t fault,
  input wire logic                mcu_reset_req,
  input wire logic [2:0]          exception_req,
  input wire logic                cpu_halt,
  input wire logic                watchdog_service
);
  logic [7:0]          aw_r, ar_r;
  rcs_pkg::rcs_fault_t f1_r, f2_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    f1_r <= fault;
    f2_r <= f1_r;
    if (!aresetn) begin
      aw_r <= 8'hFF;
      ar_r <= 8'hFF;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_r <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ar_r <= s_axi_araddr;
    end
  end
  property p_wd_cause; watchdog_service |-> s_axi_bvalid && aw_r == rcs_pkg::ADDR_CAUSE; endproperty
  a_wd_cause: assert property (p_wd_cause) else $error("service without cause write");
  property p_wd_once; $rose(s_axi_bvalid) && aw_r == 8'h00 |-> watchdog_service ##1 !watchdog_service; endproperty
  a_wd_once: assert property (p_wd_once) else $error("service pulse missing");
  property p_bit0; s_axi_rvalid && ar_r == 8'h00 |-> s_axi_rdata[0] == 1'h0 && s_axi_rdata[31:8] == 24'h0; endproperty
  a_bit0: assert property (p_bit0) else $error("cause read with bit 0 set");
  property p_rst_pulse; mcu_reset_req |=> !mcu_reset_req; endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
  property p_exc; exception_req[0] |-> f1_r.illegal_addr || f2_r.illegal_addr; endproperty
  a_exc: assert property (p_exc) else $error("exception without fault");
  property p_halt; $rose(cpu_halt) |-> f1_r.fault_on_fault || f2_r.fault_on_fault; endproperty
  a_halt: assert property (p_halt) else $error("halt without fault");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rdone: assert property (p_rdone) else $error("read answer stuck");
  c_rst: cover property (mcu_reset_req);
  c_exc: cover property (exception_req[0]);
  c_halt: cover property ($rose(cpu_halt));
endmodule

/* tb/rcs_src_model.sv */
// Purpose: On-chip reset sources feeding rcs_top
// Assumes: sel steady while go is high
// Notes:   One source per episode, all quiet while go is low
`timescale 1ns/1ps
module rcs_src_model (
  input  wire logic           aclk,
  input  wire logic [3:0]     sel,
  input  wire logic           go,
  output rcs_pkg::rcs_det_t   det,
  output rcs_pkg::rcs_instr_t instr,
  output rcs_pkg::rcs_fault_t fault
);
  always @(posedge aclk) begin
    {det, instr, fault} <= '0;
    if (go) begin
      case (sel)
        4'h0: det.ext_pin_low <= 1'h1;
        4'h1: det.wdog_timeout <= 1'h1;
        4'h2: det.clk_lost <= 1'h1;
        4'h3: det.lv_trip <= 1'h1;
        4'h4: det.debug_force_reset <= 1'h1;
        4'h5: instr <= {1'h1, 16'h1234, 5'h10};
        4'h6: instr <= {1'h1, rcs_pkg::ILLEGAL_OPCODE, 5'h10};
        4'h7: instr <= {1'h1, 16'h1234, 5'h0C};
        4'h8: instr <= {1'h1, 16'h0002, 5'h02};
        4'h9: instr <= {1'h1, 16'h0003, 5'h01};
        4'hA: fault.illegal_addr <= 1'h1;
        4'hB: fault.fault_on_fault <= 1'h1;
        default: fault.rte_format <= 1'h1;
      endcase
    end
  end
endmodule

/* tb/tb_reset_cause_status_logic.sv */
// Purpose: Self-checking bench of the reset cause status logic
// Assumes: Seed 59, one 125 MHz clock
// Notes:   Random control values and every reset source except the address error fault
`timescale 1ns/1ps
module tb_reset_cause_status_logic;
  logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, go = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] sel = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, mcu_reset_req, cpu_halt, watchdog_service, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] exception_req;
  rcs_pkg::rcs_det_t det;
  rcs_pkg::rcs_instr_t instr;
  rcs_pkg::rcs_fault_t fault;
  int mismatches = 0, n_tests = 0, n_rst = 0, n_wd = 0;
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    if (mcu_reset_req === 1'h1) n_rst++;
    if (watchdog_service === 1'h1) n_wd++;
  end
  rcs_src_model src (.aclk(aclk), .sel(sel), .go(go), .det(det), .instr(instr), .fault(fault));
  rcs_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .det(det), .instr(instr), .fault(fault), .mcu_reset_req(mcu_reset_req),
    .exception_req(exception_req), .cpu_halt(cpu_halt), .watchdog_service(watchdog_service), .irq(irq));
  task automatic test_done;
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    int n;
    @(posedge aclk);
    if (w) begin
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
    end else begin
      araddr <= a;
      {arvalid, rready} <= 2'h3;
    end
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (arvalid && arready) arvalid <= 1'h0;
      if (bready && bvalid) begin
        bready <= 1'h0;
        r = bresp;
        break;
      end
      if (rready && rvalid) begin
        rready <= 1'h0;
        q = rdata;
        r = rresp;
        break;
      end
    end
    if (n == 50) begin
      mismatches++;
      test_done();
    end
  endtask
  function automatic logic [8:0] exp_f(logic [7:0] c, int s, logic [7:0] p);
    logic [7:0] f;
    f = 8'h00;
    case (s)
      0: f[6] = 1'h1;
      1: f[5] = |c[7:6];
      2: f[2] = c[4];
      3: f[1] = c[5];
      5, 7: f[4] = 1'h1;
      8: f[4] = ~c[0] & ~c[1];
      9: f[4] = ~c[2];
      10, 11, 12: f[3] = ~c[3];
      default: f = 8'h00;
    endcase
    if (s == 3 && c[5]) f[7] = p[7];
    return (f != 8'h00 || s == 4) ? {1'h1, f} : {1'h0, p};
  endfunction
  initial begin
    int i, s, r0, w0;
    logic h, hv;
    logic [7:0] c, ex;
    logic [8:0] e;
    logic [31:0] q;
    logic [1:0] r;
    h = 1'h0;
    i = $urandom(59);
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    ex = rcs_pkg::CAUSE_POR;
    bus(1'h0, rcs_pkg::ADDR_CAUSE, 32'h0, q, r);
    chk(q, {24'h0, ex});
    bus(1'h0, 8'h10, 32'h0, q, r);
    chk({r, q[7:0]}, {rcs_pkg::RESP_SLVERR, 8'h00});
    bus(1'h1, rcs_pkg::ADDR_MASK, 32'h1, q, r);
    for (i = 0; i < 40; i++) begin
      c = 8'($urandom);
      s = (i < 13) ? i : $urandom_range(12, 0);
      bus(1'h1, rcs_pkg::ADDR_CTRL, {24'h0, c}, q, r);
      r0 = n_rst;
      w0 = n_wd;
      sel <= s[3:0];
      go <= 1'h1;
      repeat (2) @(posedge aclk);
      go <= 1'h0;
      repeat (4) @(posedge aclk);
      e = exp_f(c, s, ex);
      ex = e[7:0];
      chk(n_rst - r0, {31'h0, e[8]});
      chk(irq, e[8]);
      if (e[8]) h = 1'h0;
      hv = (s == 11) && c[3] && !h;
      if (s == 11 && c[3]) h = 1'h1;
      chk(cpu_halt, h);
      bus(1'h1, rcs_pkg::ADDR_CAUSE, $urandom, q, r);
      bus(1'h0, rcs_pkg::ADDR_CAUSE, 32'h0, q, r);
      chk(q, {24'h0, ex});
      chk(n_wd - w0, 1);
      bus(1'h0, rcs_pkg::ADDR_EVT, 32'h0, q, r);
      chk(q[2:0], {hv, (s == 10 || s == 12) && c[3], e[8]});
    end
    test_done();
  end
endmodule
bind rcs_top rcs_monitor mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .fault,
  .mcu_reset_req, .exception_req, .cpu_halt, .watchdog_service);
